// file: hdl/rrp_pkg.sv
// constants, register map and carrier types for the read range and upstream pacing block
// Functional notes
// R1: with the range-1 control bit clear, reads that fall inside the ranges are refused the smart prefetch mode.
// R2: with the range-1 control bit set, only reads that fall inside the ranges may use the smart prefetch mode.
// R3: range-1 size comes from bits 31:1 of its control register, in 2-byte steps, at most 4 GB.
// R4: each range is formed from a writable lower base word, its upper base word and its size.
// R5: the range-2 upper base register gives bits 63:32 of the range-2 base address.
// R6: range-2 size is a full 32-bit writable register, at most 4 GB.
// R7: range eligibility only counts while the smart prefetch mode enable field is nonzero.
// R8: a 3-bit pacing field decides when a second upstream read may go; code 000 waits for all completion data.
// R9: pacing codes 001, 010, 011 let the second read go at 1, 2 or 4 completion data units outstanding or fewer.
// R10: any pacing code with its top bit set lets the second read go at 8 units outstanding or fewer.
// R11: a 2-bit field splits upstream writes at 32 (00), 64 (01) or 128 (1x) byte boundaries.
// R12: an address is inside a range when it is at or above the base and below base plus size.
package rrp_pkg;

   localparam logic [7:0]  OFS_R1_BASE_LO = 8'h50;
   localparam logic [7:0]  OFS_R1_BASE_HI = 8'h54;
   localparam logic [7:0]  OFS_R1_CTL     = 8'h58;
   localparam logic [7:0]  OFS_R2_BASE_LO = 8'h5C;
   localparam logic [7:0]  OFS_R2_BASE_HI = 8'h60;
   localparam logic [7:0]  OFS_R2_SIZE    = 8'h64;
   localparam logic [7:0]  OFS_PACE       = 8'h68;

   localparam logic [31:0] ZERO_RST       = 32'h00000000;
   localparam logic [31:0] PACE_RST       = 32'hB8000000;
   localparam logic [31:0] PACE_WMASK     = 32'hF8000000;

   localparam int          R1_CTL_BIT     = 0;
   localparam int          R1_SIZE_LSB    = 1;
   localparam int          R1_SIZE_TOP    = 31;
   localparam int          PACE_LSB       = 27;
   localparam int          PACE_TOP       = 29;
   localparam int          FRAG_LSB       = 30;
   localparam int          FRAG_TOP       = 31;

   localparam logic [2:0]  PACE_ALL       = 3'h0;
   localparam logic [2:0]  PACE_ONE       = 3'h1;
   localparam logic [2:0]  PACE_TWO       = 3'h2;
   localparam logic [2:0]  PACE_FOUR      = 3'h3;
   localparam logic [15:0] THR_ALL        = 16'h0000;
   localparam logic [15:0] THR_ONE        = 16'h0001;
   localparam logic [15:0] THR_TWO        = 16'h0002;
   localparam logic [15:0] THR_FOUR       = 16'h0004;
   localparam logic [15:0] THR_EIGHT      = 16'h0008;

   localparam logic [1:0]  FRAG_32        = 2'h0;
   localparam logic [7:0]  BND_32         = 8'h20;
   localparam logic [7:0]  BND_64         = 8'h40;
   localparam logic [7:0]  BND_128        = 8'h80;

   localparam logic [3:0]  MODE_OFF       = 4'h0;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } rrp_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rrp_axi_rsp_type;

endpackage

// file: hdl/rrp_top.sv
// register file and decision logic for smart prefetch ranges, read pacing and write splitting
`timescale 1ns/10ps
module rrp_top
   import rrp_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            srst,
   input  wire rrp_axi_req_type axi_req,
   output rrp_axi_rsp_type      axi_rsp,
   input  wire logic [3:0]      smart_mode_en,
   input  wire logic            chk_req,
   input  wire logic [63:0]     chk_addr,
   output logic                 chk_done,
   output logic                 chk_smart_ok,
   input  wire logic            rd_issue,
   input  wire logic [15:0]     rd_units,
   input  wire logic            cpl_unit,
   output logic                 second_rd_ok,
   output logic [15:0]          rd_outstanding,
   input  wire logic            wr_req,
   input  wire logic [6:0]      wr_addr,
   output logic                 wr_done,
   output logic [7:0]           wr_bnd_bytes,
   output logic [7:0]           wr_first_bytes
);

   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        ar_got;
      logic [7:0]  ar_addr;
      rrp_axi_rsp_type rsp;
      logic [31:0] r1_base_lo;
      logic [31:0] r1_base_hi;
      logic [31:0] r1_ctl;
      logic [31:0] r2_base_lo;
      logic [31:0] r2_base_hi;
      logic [31:0] r2_size;
      logic [31:0] pace;
      logic        chk_done;
      logic        chk_ok;
      logic [15:0] outstanding;
      logic        send_ok;
      logic        wr_done;
      logic [7:0]  wr_bnd;
      logic [7:0]  wr_first;
   } rrp_state_type;

   rrp_state_type st_q;
   rrp_state_type st_d;

   // byte-lane merge shared by every writable register
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // half-open window, 65-bit sum so a range ending at the top of memory cannot wrap
   function automatic logic in_window(input logic [63:0] addr,
                                      input logic [63:0] base,
                                      input logic [31:0] size);
      logic [64:0] limit;
      limit = {1'b0, base} + {33'h0, size};
      return (addr >= base) && ({1'b0, addr} < limit); // R12
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a == OFS_R1_BASE_LO) || (a == OFS_R1_BASE_HI) || (a == OFS_R1_CTL) ||
             (a == OFS_R2_BASE_LO) || (a == OFS_R2_BASE_HI) || (a == OFS_R2_SIZE) ||
             (a == OFS_PACE);
   endfunction

   logic [63:0] r1_base;
   logic [63:0] r2_base;
   logic [31:0] r1_size;
   logic        in_r1;
   logic        in_r2;
   logic [2:0]  pace_code;
   logic [1:0]  frag_code;
   logic [15:0] thr;
   logic [7:0]  bnd;

   assign r1_base   = {st_q.r1_base_hi, st_q.r1_base_lo}; // R4
   assign r2_base   = {st_q.r2_base_hi, st_q.r2_base_lo}; // R5
   assign r1_size   = {st_q.r1_ctl[R1_SIZE_TOP:R1_SIZE_LSB], 1'b0}; // R3
   assign in_r1     = in_window(chk_addr, r1_base, r1_size);
   assign in_r2     = in_window(chk_addr, r2_base, st_q.r2_size); // R6
   assign pace_code = st_q.pace[PACE_TOP:PACE_LSB];
   assign frag_code = st_q.pace[FRAG_TOP:FRAG_LSB];

   always_comb begin
      unique casez (pace_code)
         PACE_ALL:  thr = THR_ALL; // R8
         PACE_ONE:  thr = THR_ONE; // R9
         PACE_TWO:  thr = THR_TWO; // R9
         PACE_FOUR: thr = THR_FOUR; // R9
         default:   thr = THR_EIGHT; // R10
      endcase
   end

   always_comb begin
      if (frag_code[1]) begin
         bnd = BND_128; // R11
      end else if (frag_code == FRAG_32) begin
         bnd = BND_32; // R11
      end else begin
         bnd = BND_64; // R11
      end
   end

   always_comb begin
      logic [7:0]  wa;
      logic [31:0] rd_v;
      logic        any_in;
      wa     = st_q.aw_addr;
      rd_v   = ZERO_RST;
      any_in = 1'b0;
      st_d   = st_q;

      // write address and data are captured independently, in either order
      if (axi_req.awvalid && st_q.rsp.awready) begin
         st_d.aw_got  = 1'b1;
         st_d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && st_q.rsp.wready) begin
         st_d.w_got  = 1'b1;
         st_d.w_data = axi_req.wdata;
         st_d.w_strb = axi_req.wstrb;
      end
      if (st_q.rsp.bvalid && axi_req.bready) begin
         st_d.rsp.bvalid = 1'b0;
      end

      if (st_q.aw_got && st_q.w_got && !st_q.rsp.bvalid) begin
         st_d.aw_got     = 1'b0;
         st_d.w_got      = 1'b0;
         st_d.rsp.bvalid = 1'b1;
         st_d.rsp.bresp  = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
         if (wa == OFS_R1_BASE_LO) begin
            st_d.r1_base_lo = merge_strb(st_q.r1_base_lo, st_q.w_data, st_q.w_strb); // R4
         end
         if (wa == OFS_R1_BASE_HI) begin
            st_d.r1_base_hi = merge_strb(st_q.r1_base_hi, st_q.w_data, st_q.w_strb); // R4
         end
         if (wa == OFS_R1_CTL) begin
            st_d.r1_ctl = merge_strb(st_q.r1_ctl, st_q.w_data, st_q.w_strb); // R3
         end
         if (wa == OFS_R2_BASE_LO) begin
            st_d.r2_base_lo = merge_strb(st_q.r2_base_lo, st_q.w_data, st_q.w_strb); // R4
         end
         if (wa == OFS_R2_BASE_HI) begin
            st_d.r2_base_hi = merge_strb(st_q.r2_base_hi, st_q.w_data, st_q.w_strb); // R5
         end
         if (wa == OFS_R2_SIZE) begin
            st_d.r2_size = merge_strb(st_q.r2_size, st_q.w_data, st_q.w_strb); // R6
         end
         if (wa == OFS_PACE) begin
            // reserved low bits stay zero
            st_d.pace = merge_strb(st_q.pace, st_q.w_data, st_q.w_strb) & PACE_WMASK;
         end
      end
      // no new address or data while a write is held or its answer waits
      st_d.rsp.awready = !st_d.aw_got && !st_d.rsp.bvalid;
      st_d.rsp.wready  = !st_d.w_got && !st_d.rsp.bvalid;

      // read: address taken, data answered on the following edge
      if (st_q.rsp.rvalid && axi_req.rready) begin
         st_d.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && st_q.rsp.arready) begin
         st_d.ar_got  = 1'b1;
         st_d.ar_addr = axi_req.araddr;
      end
      if (st_q.ar_got && !st_q.rsp.rvalid) begin
         unique case (st_q.ar_addr)
            OFS_R1_BASE_LO: rd_v = st_q.r1_base_lo;
            OFS_R1_BASE_HI: rd_v = st_q.r1_base_hi;
            OFS_R1_CTL:     rd_v = st_q.r1_ctl;
            OFS_R2_BASE_LO: rd_v = st_q.r2_base_lo;
            OFS_R2_BASE_HI: rd_v = st_q.r2_base_hi;
            OFS_R2_SIZE:    rd_v = st_q.r2_size;
            OFS_PACE:       rd_v = st_q.pace;
            default:        rd_v = ZERO_RST;
         endcase
         st_d.ar_got     = 1'b0;
         st_d.rsp.rvalid = 1'b1;
         st_d.rsp.rdata  = rd_v;
         st_d.rsp.rresp  = mapped(st_q.ar_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      st_d.rsp.arready = !st_d.ar_got && !st_d.rsp.rvalid;

      // range eligibility, one cycle after the request
      st_d.chk_done = chk_req;
      if (chk_req) begin
         any_in = in_r1 || in_r2;
         if (smart_mode_en == MODE_OFF) begin
            st_d.chk_ok = 1'b0; // R7
         end else if (st_q.r1_ctl[R1_CTL_BIT]) begin
            st_d.chk_ok = any_in; // R2
         end else begin
            st_d.chk_ok = !any_in; // R1
         end
      end

      // completion data still owed to the last request of the channel
      if (rd_issue) begin
         st_d.outstanding = rd_units;
      end else if (cpl_unit && (st_q.outstanding != THR_ALL)) begin
         st_d.outstanding = st_q.outstanding - THR_ONE;
      end
      st_d.send_ok = (st_d.outstanding <= thr); // R8

      // first fragment runs up to the next boundary
      st_d.wr_done = wr_req;
      if (wr_req) begin
         st_d.wr_bnd   = bnd; // R11
         // boundary is a power of two, so one less is the offset mask
         st_d.wr_first = bnd - ({1'b0, wr_addr} & (bnd - 8'h01)); // R11
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q             <= '0;
         st_q.r1_base_lo  <= ZERO_RST;
         st_q.r1_base_hi  <= ZERO_RST;
         st_q.r1_ctl      <= ZERO_RST;
         st_q.r2_base_lo  <= ZERO_RST;
         st_q.r2_base_hi  <= ZERO_RST;
         st_q.r2_size     <= ZERO_RST;
         st_q.pace        <= PACE_RST;
         st_q.send_ok     <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign axi_rsp        = st_q.rsp;
   assign chk_done       = st_q.chk_done;
   assign chk_smart_ok   = st_q.chk_ok;
   assign second_rd_ok   = st_q.send_ok;
   assign rd_outstanding = st_q.outstanding;
   assign wr_done        = st_q.wr_done;
   assign wr_bnd_bytes   = st_q.wr_bnd;
   assign wr_first_bytes = st_q.wr_first;

endmodule // rrp_top

// file: tb/rrp_properties.sv
// port assertions for the read range and pacing block
`timescale 1ns/10ps
module rrp_properties
   import rrp_pkg::*;
(
   input wire logic            sys_clk,
   input wire logic            srst,
   input wire rrp_axi_req_type axi_req,
   input wire rrp_axi_rsp_type axi_rsp,
   input wire logic [3:0]      smart_mode_en,
   input wire logic            chk_req,
   input wire logic            chk_done,
   input wire logic            chk_smart_ok,
   input wire logic            rd_issue,
   input wire logic [15:0]     rd_units,
   input wire logic            cpl_unit,
   input wire logic            second_rd_ok,
   input wire logic [15:0]     rd_outstanding,
   input wire logic            wr_req,
   input wire logic [6:0]      wr_addr,
   input wire logic            wr_done,
   input wire logic [7:0]      wr_bnd_bytes,
   input wire logic [7:0]      wr_first_bytes
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence ar_taken;
      axi_req.arvalid && axi_rsp.arready;
   endsequence
   sequence r_held;
      axi_rsp.rvalid && !axi_req.rready;
   endsequence
   chk_answer_a: assert property (chk_req |=> chk_done) else $error("check answer missing");
   chk_quiet_a: assert property (!chk_req |=> !chk_done) else $error("check answer unasked");
   mode_off_a: assert property (chk_req && smart_mode_en == MODE_OFF |=> !chk_smart_ok) else $error("mode off");
   wr_bnd_a: assert property (wr_req |=> wr_done && wr_bnd_bytes inside {8'h20, 8'h40, 8'h80})
      else $error("split size");
   wr_first_a: assert property (wr_done |-> wr_first_bytes == wr_bnd_bytes - ({1'b0, $past(wr_addr)}
      & (wr_bnd_bytes - 8'h01))) else $error("first piece");
   rd_load_a: assert property (rd_issue |=> rd_outstanding == $past(rd_units)) else $error("load");
   rd_drain_a: assert property (cpl_unit && !rd_issue && rd_outstanding != 16'h0000
      |=> rd_outstanding == $past(rd_outstanding) - 16'h0001) else $error("drain");
   idle_ok_a: assert property (rd_outstanding == 16'h0000 |-> second_rd_ok) else $error("idle");
   ok_cap_a: assert property (second_rd_ok |-> rd_outstanding <= 16'h0008) else $error("cap");
   read_answer_a: assert property (ar_taken |-> ##[1:2] axi_rsp.rvalid) else $error("no read answer");
   read_stand_a: assert property (r_held |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read");
endmodule // rrp_properties

bind rrp_top rrp_properties u_prop (.sys_clk, .srst, .axi_req, .axi_rsp, .smart_mode_en, .chk_req, .chk_done,
   .chk_smart_ok, .rd_issue, .rd_units, .cpl_unit, .second_rd_ok, .rd_outstanding, .wr_req, .wr_addr,
   .wr_done, .wr_bnd_bytes, .wr_first_bytes);

// file: tb/rrp_link_model.sv
// link partner model: sends reads and returns completion data units
`timescale 1ns/10ps
module rrp_link_model (
   input  wire logic        sys_clk,
   output logic             rd_issue,
   output logic [15:0]      rd_units,
   output logic             cpl_unit
);
   initial begin
      rd_issue = 1'b0;
      rd_units = 16'h0000;
      cpl_unit = 1'b0;
   end
   task issue(input logic [15:0] u);
      @(posedge sys_clk);
      rd_issue <= 1'b1;
      rd_units <= u;
      @(posedge sys_clk);
      rd_issue <= 1'b0;
      // stale count would hide a late sample
      rd_units <= ~u;
   endtask
   task complete(input int gap);
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      cpl_unit <= 1'b1;
      @(posedge sys_clk);
      cpl_unit <= 1'b0;
   endtask
endmodule // rrp_link_model

// file: tb/read_range_and_upstream_pacing_test.sv
// self-checking bench for the read range and pacing block
`timescale 1ns/10ps
module read_range_and_upstream_pacing_test
   import rrp_pkg::*;
();
   logic sys_clk, srst, chk_req, chk_done, chk_ok, rd_issue, cpl_unit, rd_ok, wr_req, wr_done;
   rrp_axi_req_type req;
   rrp_axi_rsp_type rsp;
   logic [3:0]  mode_en;
   logic [63:0] chk_addr;
   logic [15:0] rd_units, rd_out;
   logic [6:0]  wr_addr;
   logic [7:0]  wr_bnd, wr_first;
   int          n_mismatch, comparisons;
   logic [63:0] tbl_a [7] = '{64'h100001000, 64'h1000010FF, 64'h100001100, 64'h100000FFF, 64'h21, 64'h22, 64'h1000};
   logic        tbl_in [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   rrp_top dut (.sys_clk, .srst, .axi_req(req), .axi_rsp(rsp), .smart_mode_en(mode_en), .chk_req, .chk_addr,
      .chk_done, .chk_smart_ok(chk_ok), .rd_issue, .rd_units, .cpl_unit, .second_rd_ok(rd_ok),
      .rd_outstanding(rd_out), .wr_req, .wr_addr, .wr_done, .wr_bnd_bytes(wr_bnd), .wr_first_bytes(wr_first));
   rrp_link_model u_link (.sys_clk, .rd_issue, .rd_units, .cpl_unit);

   task check(input logic [63:0] s, input logic [63:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit da, dw;
      da = 0;
      dw = 0;
      @(posedge sys_clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      // awready stays low after a take until the response is done
      do begin
         @(posedge sys_clk);
         da |= rsp.awready;
         dw |= rsp.wready;
         if (da) req.awvalid <= 1'b0;
         if (dw) req.wvalid <= 1'b0;
      end while (!(da && dw));
      do @(posedge sys_clk); while (!rsp.bvalid);
      req.bready <= 1'b0;
      check(rsp.bresp, r);
   endtask
   task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge sys_clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do @(posedge sys_clk); while (!rsp.arready);
      req.arvalid <= 1'b0;
      do @(posedge sys_clk); while (!rsp.rvalid);
      req.rready <= 1'b0;
      check(rsp.rdata, d);
      check(rsp.rresp, r);
   endtask
   task chk(input logic [63:0] a, input logic e);
      @(posedge sys_clk);
      chk_req <= 1'b1;
      chk_addr <= a;
      @(posedge sys_clk);
      chk_req <= 1'b0;
      chk_addr <= ~a;
      #1;
      check(chk_done, 1'b1);
      check(chk_ok, e);
   endtask
   task t_regs();
      for (int i = 0; i < 7; i++) axi_rd(8'h50 + 8'(4 * i), i == 6 ? 32'hB8000000 : 32'h0, RESP_OKAY);
      axi_rd(8'h70, 32'h0, RESP_SLVERR);
      axi_wr(8'h70, 32'h12345678, RESP_SLVERR);
      axi_wr(OFS_PACE, 32'hFFFFFFFF, RESP_OKAY);
      axi_rd(OFS_PACE, 32'hF8000000, RESP_OKAY);
      axi_wr(OFS_R2_SIZE, 32'hFFFFFFFF, RESP_OKAY);
      axi_rd(OFS_R2_SIZE, 32'hFFFFFFFF, RESP_OKAY);
   endtask
   task t_range();
      axi_wr(OFS_R2_BASE_LO, 32'h00001000, RESP_OKAY);
      axi_wr(OFS_R2_BASE_HI, 32'h00000001, RESP_OKAY);
      axi_wr(OFS_R2_SIZE, 32'h00000100, RESP_OKAY);
      for (int c = 0; c < 2; c++) begin
         axi_wr(OFS_R1_CTL, 32'h22 | c, RESP_OKAY);
         for (int i = 0; i < 7; i++) chk(tbl_a[i], c ? tbl_in[i] : !tbl_in[i]);
      end
      mode_en <= MODE_OFF;
      chk(tbl_a[0], 1'b0);
      chk(tbl_a[2], 1'b0);
      mode_en <= 4'h5;
      // move range 1 up to 0x2_0000_0040, size stays 0x22, control bit stays set
      axi_wr(OFS_R1_BASE_HI, 32'h00000002, RESP_OKAY);
      axi_wr(OFS_R1_BASE_LO, 32'h00000040, RESP_OKAY);
      axi_rd(OFS_R1_BASE_HI, 32'h00000002, RESP_OKAY);
      axi_rd(OFS_R1_BASE_LO, 32'h00000040, RESP_OKAY);
      chk(64'h200000040, 1'b1);
      chk(64'h200000061, 1'b1);
      chk(64'h200000062, 1'b0);
      chk(64'h000000021, 1'b0);
   endtask
   task t_pace();
      logic [15:0] thr;
      for (int c = 0; c < 8; c++) begin
         thr = c[2] ? 16'h0008 : (c == 3 ? 16'h0004 : 16'(c));
         axi_wr(OFS_PACE, {2'b00, 3'(c), 27'h0}, RESP_OKAY);
         u_link.issue(16'h000A);
         #1;
         check(rd_ok, 1'b0);
         for (int k = 9; k >= 0; k--) begin
            u_link.complete(k % 3);
            #1;
            check(rd_out, 16'(k));
            check(rd_ok, 16'(k) <= thr);
         end
      end
   endtask
   task t_split();
      logic [7:0] b;
      for (int f = 0; f < 4; f++) begin
         b = f[1] ? 8'h80 : (f[0] ? 8'h40 : 8'h20);
         axi_wr(OFS_PACE, {2'(f), 30'h0}, RESP_OKAY);
         @(posedge sys_clk);
         wr_req <= 1'b1;
         wr_addr <= 7'h45;
         @(posedge sys_clk);
         wr_req <= 1'b0;
         wr_addr <= 7'h3A;
         #1;
         check(wr_done, 1'b1);
         check(wr_bnd, b);
         check(wr_first, b - (8'h45 & (b - 8'h01)));
      end
   endtask
   task tally_and_finish();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      srst = 1'b1;
      req = '0;
      mode_en = 4'h5;
      chk_req = 1'b0;
      chk_addr = 64'h0;
      wr_req = 1'b0;
      wr_addr = 7'h0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_range();
      t_pace();
      t_split();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule // read_range_and_upstream_pacing_test
